/* sram_port_defs.svh */
// Purpose: Shared constants for the flow-through burst SRAM port.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// ==========================================================
// Geometry
`define SP_ADDR_W      10
`define SP_LANES       4
`define SP_LANE_W      8
`define SP_BURST_W     2
`define SP_FIFO_DEPTH  16

// ==========================================================
// Burst counter values, strap levels and synchroniser stages
`define SP_CNT_ZERO    2'h0
`define SP_CNT_ONE     2'h1
`define SP_STRAP_LIN   1'b0
`define SP_SYNC_STAGES 2

`endif

/* sram_port_pkg.sv */
// Purpose: Types for the flow-through burst SRAM port.
// Assumes: Nothing is imported; users write sram_port_pkg::name.
// Notes:   States are one-hot.
package sram_port_pkg;

  // ==========================================================
  // Access state
  typedef enum logic [2:0] {
    ST_DESEL  = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SLEEP  = 3'b100
  } port_state_t;

endpackage

/* sram_wr_fifo.sv */
// Purpose: Write buffer between the captured write data and the array.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Read data are muxed straight from storage; full and empty are exact.
`timescale 1ns/10ps
module sram_wr_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW-1:0]    rd_ptr_nxt;
  logic [PW:0]      count_r;
  logic [PW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != DEPTH[PW:0]);
  assign out_valid = (count_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_ptr_nxt = push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop) begin
      count_nxt = (PW + 1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = (PW + 1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Storage has no reset; the head word is read combinationally from it
  always_ff @(posedge core_clk) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data;
    end
  end

  always_comb begin
    out_data = store_r[rd_ptr_r];
  end

endmodule

/* sram_burst_port.sv */
// Purpose: Device side of a synchronous flow-through SRAM with a 2-bit burst counter.
// Assumes: All bus inputs are synchronous to core_clk; drive, sleep, strap and
//          test pins are asynchronous and pass two flip-flops first.
// Notes:   Writes go through a 16-word buffer before reaching the array.
`timescale 1ns/10ps
`include "sram_port_defs.svh"

// Notes on behaviour
// - Burst step sampled each edge advances the burst address during a burst.
// - Processor strobe low captures address and loads low two bits into counter.
// - Controller strobe low captures address and loads low two bits into counter.
// - With both strobes asserted and primary chip select low, only the processor strobe is honoured.
// - Processor strobe is ignored while primary chip select is high.
// - Byte writes happen only with byte write gate sampled low.
// - Sleep request high enters a low-activity state keeping stored contents.
// - Host holds sleep low or open; input is pulled down internally.
// - Write data are captured on the rising clock edge.
// - Read data are those addressed at the preceding edge (flow-through).
// - Data and parity drive while output drive is low, float while high.
// - Outputs float in write data phase, first cycle after deselect, deselected.
// - Parity lines act like data; each written under its lane select.
// - Strap low selects linear order; high or open selects interleaved.
// - Test serial output changes on falling test clock edge.
// - Test data and mode inputs are sampled on rising test clock edge.
// - Interleaved order XORs the start value with 01, 10, 11.
// - Linear order increments by one and wraps from 11 to 00.
// - Global write low writes all bytes regardless of lane selects and gate.
// - Chip selects are evaluated only when a strobe loads a new address.
module sram_burst_port #(
  parameter int ADDR_W     = `SP_ADDR_W,
  parameter int LANES      = `SP_LANES,
  parameter int FIFO_DEPTH = `SP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // Address and selects
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic                     ce1_n,
  input  wire logic                     ce2,
  input  wire logic                     ce3_n,
  // Burst control
  input  wire logic                     cpu_addr_strobe_n,
  input  wire logic                     cache_ctl_addr_strobe_n,
  input  wire logic                     burst_step_n,
  // Write control
  input  wire logic                     all_bytes_write_n,
  input  wire logic                     byte_write_gate_n,
  input  wire logic [LANES-1:0]         byte_lane_select_n,
  // Data lines, split into in, out and enable
  input  wire logic [LANES*8-1:0]       data_in,
  output logic      [LANES*8-1:0]       data_out,
  output logic                          data_oe,
  // Parity lines, split into in, out and enable
  input  wire logic [LANES-1:0]         parity_in,
  output logic      [LANES-1:0]         parity_out,
  output logic                          parity_oe,
  // Asynchronous controls
  input  wire logic                     out_drive_n,
  input  wire logic                     sleep_request,
  input  wire logic                     burst_order_strap,
  // Test port
  input  wire logic                     tck,
  input  wire logic                     tdi,
  input  wire logic                     tms,
  output logic                          tdo,
  // Status
  output logic                          sleeping,
  output logic                          write_accept
);
  localparam int LW = `SP_LANE_W;
  localparam int BW = `SP_BURST_W;
  localparam int WW = LANES * (LW + 1);
  localparam int QW = ADDR_W + WW + LANES;

  // ==========================================================
  // Synchronisers for asynchronous pins
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;

  // Left running through reset so the strap level is settled at release
  always_ff @(posedge core_clk) begin
    sync1_r <= {tms, tdi, tck, sleep_request, burst_order_strap, out_drive_n};
    sync2_r <= sync1_r;
  end

  logic drive_n_s;
  logic strap_s;
  logic sleep_s;
  logic tck_s;
  logic tdi_s;
  logic tms_s;
  assign {tms_s, tdi_s, tck_s, sleep_s, strap_s, drive_n_s} = sync2_r;

  // ==========================================================
  // Burst order strap, caught once after reset release
  logic interleave_r;
  logic interleave_nxt;
  logic strap_taken_r;
  logic strap_taken_nxt;

  always_comb begin
    interleave_nxt  = interleave_r;
    strap_taken_nxt = 1'b1;
    // strap selects order; static, so sampled once
    if (!strap_taken_r) begin
      interleave_nxt = (strap_s != `SP_STRAP_LIN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      interleave_r  <= 1'b1;
      strap_taken_r <= 1'b0;
    end else begin
      interleave_r  <= interleave_nxt;
      strap_taken_r <= strap_taken_nxt;
    end
  end

  // ==========================================================
  // Burst sequencing
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                              input logic [BW-1:0] cnt,
                                              input logic          ilv);
    // interleaved xor; linear increment with wrap
    burst_low = ilv ? (start ^ cnt) : BW'(start + cnt);
  endfunction

  sram_port_pkg::port_state_t state_r;
  sram_port_pkg::port_state_t state_nxt;
  logic [ADDR_W-1:0] base_r;
  logic [ADDR_W-1:0] base_nxt;
  logic [BW-1:0]     cnt_r;
  logic [BW-1:0]     cnt_nxt;
  logic              wr_phase_r;
  logic              wr_phase_nxt;
  logic              first_r;
  logic              first_nxt;

  logic              load_cpu;
  logic              load_ctl;
  logic              load;
  logic              selected;
  logic              active;
  logic              wr_req;
  logic [LANES-1:0]  lane_en;
  logic [ADDR_W-1:0] acc_addr;
  logic              acc_valid;
  logic              acc_write;

  always_comb begin
    // processor strobe gated by primary select
    load_cpu = !cpu_addr_strobe_n && !ce1_n;
    // processor strobe wins over controller strobe
    load_ctl = !cache_ctl_addr_strobe_n && !load_cpu;
    load     = (load_cpu || load_ctl) && (state_r != sram_port_pkg::ST_SLEEP);
    // selects only matter on a load
    selected = !ce1_n && ce2 && !ce3_n;
    active   = (state_r == sram_port_pkg::ST_ACTIVE);
    // global write covers all lanes; byte gate qualifies lanes
    if (!all_bytes_write_n) begin
      lane_en = '1;
    end else if (!byte_write_gate_n) begin
      lane_en = ~byte_lane_select_n;
    end else begin
      lane_en = '0;
    end
    wr_req = (lane_en != '0);

    state_nxt    = state_r;
    base_nxt     = base_r;
    cnt_nxt      = cnt_r;
    acc_valid    = 1'b0;
    acc_write    = 1'b0;
    first_nxt    = 1'b0;
    acc_addr     = {base_r[ADDR_W-1:BW], burst_low(base_r[BW-1:0], cnt_r, interleave_r)};

    case (state_r)
      sram_port_pkg::ST_SLEEP: begin
        // no access while asleep; array untouched
        if (!sleep_s) begin
          state_nxt = sram_port_pkg::ST_DESEL;
        end
      end
      sram_port_pkg::ST_DESEL,
      sram_port_pkg::ST_ACTIVE: begin
        if (sleep_s) begin
          // enter sleep; pending access is dropped
          state_nxt = sram_port_pkg::ST_SLEEP;
        end else if (load) begin
          base_nxt = addr;
          cnt_nxt  = `SP_CNT_ZERO;
          if (selected) begin
            state_nxt = sram_port_pkg::ST_ACTIVE;
            first_nxt = (state_r == sram_port_pkg::ST_DESEL);
            acc_addr  = addr;
            acc_valid = 1'b1;
            // Write inputs count on a controller-started cycle only
            acc_write = load_ctl && wr_req;
          end else begin
            state_nxt = sram_port_pkg::ST_DESEL;
          end
        end else if (active) begin
          acc_valid = 1'b1;
          acc_write = wr_req;
          // step advances; otherwise hold and repeat
          if (!burst_step_n) begin
            cnt_nxt  = BW'(cnt_r + `SP_CNT_ONE);
            acc_addr = {base_r[ADDR_W-1:BW],
                        burst_low(base_r[BW-1:0], cnt_nxt, interleave_r)};
          end
        end
      end
      default: begin
        state_nxt = sram_port_pkg::ST_DESEL;
      end
    endcase
    wr_phase_nxt = acc_write;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= sram_port_pkg::ST_DESEL;
      base_r     <= '0;
      cnt_r      <= `SP_CNT_ZERO;
      wr_phase_r <= 1'b0;
      first_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      base_r     <= base_nxt;
      cnt_r      <= cnt_nxt;
      wr_phase_r <= wr_phase_nxt;
      first_r    <= first_nxt;
    end
  end

  // ==========================================================
  // Write buffer
  logic [WW-1:0] wr_word;
  logic [QW-1:0] q_in;
  logic [QW-1:0] q_out;
  logic          q_valid;
  logic          q_drain;

  // pack each lane with its parity bit
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_pack
      assign wr_word[g*(LW+1) +: LW+1] = {parity_in[g], data_in[g*LW +: LW]};
    end
  endgenerate

  assign q_in    = {acc_addr, lane_en, wr_word};
  // Draining stops while asleep, so queued writes wait in the buffer until wake
  assign q_drain = (state_r != sram_port_pkg::ST_SLEEP);

  sram_wr_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) sram_wr_fifo_inst (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (acc_write),
    .in_ready  (write_accept),
    .in_data   (q_in),
    .out_valid (q_valid),
    .out_ready (q_drain),
    .out_data  (q_out)
  );

  // ==========================================================
  // Array with registered read
  logic [WW-1:0]     array_r [2**ADDR_W];
  logic [WW-1:0]     rd_word_r;
  logic [ADDR_W-1:0] q_addr;
  logic [LANES-1:0]  q_lanes;
  logic [WW-1:0]     q_word;
  assign {q_addr, q_lanes, q_word} = q_out;

  // lane-wise parity writes
  // One process owns the array; per-lane processes would each drive all of it
  always_ff @(posedge core_clk) begin
    if (q_valid && q_drain) begin
      for (int i = 0; i < LANES; i++) begin
        if (q_lanes[i]) begin
          array_r[q_addr][i*(LW+1) +: LW+1] <= q_word[i*(LW+1) +: LW+1];
        end
      end
    end
  end

  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign data_out[g*LW +: LW] = rd_word_r[g*(LW+1) +: LW];
      assign parity_out[g]        = rd_word_r[g*(LW+1) + LW];
    end
  endgenerate

  // data addressed at this edge appear after it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_word_r <= '0;
    end else if (acc_valid && !acc_write) begin
      rd_word_r <= array_r[acc_addr];
    end
  end

  // ==========================================================
  // Output drive
  always_comb begin
    // drive only with drive input low; float on write, first, deselect
    data_oe   = !drive_n_s && (state_r == sram_port_pkg::ST_ACTIVE) && !wr_phase_r && !first_r;
    parity_oe = data_oe;
    sleeping  = (state_r == sram_port_pkg::ST_SLEEP);
  end

  // ==========================================================
  // Test port edges
  logic tck_d_r;
  logic tck_d_nxt;
  logic bypass_r;
  logic bypass_nxt;
  logic tdo_r;
  logic tdo_nxt;

  always_comb begin
    tck_d_nxt  = tck_s;
    bypass_nxt = bypass_r;
    tdo_nxt    = tdo_r;
    // sample serial and mode inputs on rising test clock
    if (tck_s && !tck_d_r) begin
      bypass_nxt = tdi_s && !tms_s;
    end
    // serial output changes on falling test clock
    if (!tck_s && tck_d_r) begin
      tdo_nxt = bypass_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tck_d_r  <= 1'b0;
      bypass_r <= 1'b0;
      tdo_r    <= 1'b0;
    end else begin
      tck_d_r  <= tck_d_nxt;
      bypass_r <= bypass_nxt;
      tdo_r    <= tdo_nxt;
    end
  end

  assign tdo = tdo_r;

endmodule

/* sram_burst_port_sva.sv */
// Purpose: Pin-level checks on the flow-through burst SRAM port.
// Assumes: Bound into every sram_burst_port; one clock domain.
// Notes:   Async pins are taken to reach the outputs in two or three edges.
`timescale 1ns/10ps
module sram_burst_port_sva #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             reset,
  // Bus inputs
  input wire logic             cpu_addr_strobe_n,
  input wire logic             cache_ctl_addr_strobe_n,
  input wire logic             ce2,
  input wire logic             all_bytes_write_n,
  input wire logic             byte_write_gate_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  // Async pins
  input wire logic             out_drive_n,
  input wire logic             sleep_request,
  input wire logic             tck,
  // Outputs
  input wire logic             data_oe,
  input wire logic             parity_oe,
  input wire logic             tdo,
  input wire logic             sleeping
);
  default clocking dck @(posedge core_clk); endclocking
  default disable iff (reset);

  logic wr_cyc;
  // A processor load never writes, so only cycles without it count
  assign wr_cyc = cpu_addr_strobe_n && (!all_bytes_write_n ||
                  (!byte_write_gate_n && !(&byte_lane_select_n)));

  property p_drive_off;
    out_drive_n [*4] |-> !data_oe;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("data driven, drive high");

  property p_drive_src;
    data_oe |-> !$past(out_drive_n, 2) || !$past(out_drive_n, 3);
  endproperty
  a_drive_src: assert property (p_drive_src) else $error("data driven unasked");

  property p_write_float;
    wr_cyc |=> !data_oe;
  endproperty
  a_write_float: assert property (p_write_float) else $error("driven after write");

  property p_desel_float;
    (!cache_ctl_addr_strobe_n && !ce2) |=> !data_oe [*2];
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("driven after deselect");

  property p_parity_oe;
    parity_oe == data_oe;
  endproperty
  a_parity_oe: assert property (p_parity_oe) else $error("parity drive differs");

  property p_sleep_in;
    sleep_request [*5] |-> sleeping && !data_oe;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");

  property p_sleep_out;
    !sleep_request [*6] |-> !sleeping;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("sleep not left");

  property p_tdo_fall;
    $changed(tdo) |-> !$past(tck, 2) || !$past(tck, 3) || !$past(tck, 4);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("test output moved, clock high");
endmodule

bind sram_burst_port sram_burst_port_sva #(.LANES(LANES)) sram_burst_port_sva_inst (
  .core_clk, .reset, .cpu_addr_strobe_n, .cache_ctl_addr_strobe_n, .ce2,
  .all_bytes_write_n, .byte_write_gate_n, .byte_lane_select_n, .out_drive_n,
  .sleep_request, .tck, .data_oe, .parity_oe, .tdo, .sleeping);

/* sram_host_model.sv */
// Purpose: Cache controller side of the burst SRAM bus, one cycle a call.
// Assumes: Bus changes at the falling edge of core_clk.
// Notes:   A released data wire toggles each cycle instead of holding.
`timescale 1ns/10ps
module sram_host_model (
  // Clock
  input  wire logic        core_clk,
  // Bus toward the port
  output logic [9:0]       addr,
  output logic             ce1_n,
  output logic             ce2,
  output logic             ce3_n,
  output logic             pstb_n,
  output logic             cstb_n,
  output logic             step_n,
  output logic             allw_n,
  output logic             gate_n,
  output logic [3:0]       lane_n,
  // Resolved data wire
  output logic [31:0]      wd,
  output logic [3:0]       wp,
  input  wire logic [31:0] rd,
  input  wire logic [3:0]  rp,
  input  wire logic        oe
);
  logic [35:0] drv = 36'h0;
  logic [35:0] last = 36'h0;
  logic        own = 1'b0;

  assign {wp, wd} = own ? drv : (oe ? {rp, rd} : ~last);
  always @(posedge core_clk) last <= {wp, wd};
  initial {addr, ce1_n, ce2, ce3_n, pstb_n, cstb_n, step_n, allw_n, gate_n, lane_n} =
          {10'h0, 3'b010, 5'h1f, 4'hf};

  task automatic cyc(input logic [2:0] stb, input logic [1:0] wr, input logic [3:0] ln,
                     input logic [2:0] cs, input logic [9:0] a, input logic [35:0] d);
    {pstb_n, cstb_n, step_n} = stb;
    {allw_n, gate_n} = wr;
    lane_n = ln;
    {ce1_n, ce2, ce3_n} = cs;
    addr = a;
    drv = d;
    own = !wr[1] || (!wr[0] && ln != 4'hf);
    @(negedge core_clk);
  endtask
endmodule

/* sram_burst_port_test.sv */
// Purpose: Self-checking bench for the flow-through burst SRAM port.
// Assumes: Host model drives the bus; the bench drives the async pins.
// Notes:   Reads wait three idle cycles after writes, as buffered data lag.
`timescale 1ns/10ps
module sram_burst_port_test;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        out_drive_n = 1'b0;
  logic        sleep_request = 1'b0;
  logic        burst_order_strap = 1'b1;
  logic        tck = 1'b0;
  logic        tdi = 1'b0;
  logic        tms = 1'b0;
  logic [9:0]  addr;
  logic        ce1_n, ce2, ce3_n, pstb_n, cstb_n, step_n, allw_n, gate_n;
  logic [3:0]  lane_n, pin, pout;
  logic [31:0] din, dout;
  logic        oe, poe, tdo, sleeping, write_accept;
  logic [35:0] exp_mem [0:15];
  int          errors = 0;
  int          checks = 0;
  int          cyc_cnt = 0;

  always #50 core_clk = ~core_clk;

  sram_host_model sram_host_model_inst (
    .core_clk, .addr, .ce1_n, .ce2, .ce3_n, .pstb_n, .cstb_n, .step_n, .allw_n,
    .gate_n, .lane_n, .wd(din), .wp(pin), .rd(dout), .rp(pout), .oe);

  sram_burst_port sram_burst_port_inst (
    .core_clk, .reset, .addr, .ce1_n, .ce2, .ce3_n, .cpu_addr_strobe_n(pstb_n),
    .cache_ctl_addr_strobe_n(cstb_n), .burst_step_n(step_n), .all_bytes_write_n(allw_n),
    .byte_write_gate_n(gate_n), .byte_lane_select_n(lane_n), .data_in(din), .data_out(dout),
    .data_oe(oe), .parity_in(pin), .parity_out(pout), .parity_oe(poe), .out_drive_n,
    .sleep_request, .burst_order_strap, .tck, .tdi, .tms, .tdo, .sleeping, .write_accept);

  // ==========================================================
  // Shared helpers
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [2:0] s, input logic [1:0] w, input logic [3:0] l,
                     input logic [2:0] c, input logic [9:0] a, input logic [35:0] d);
    sram_host_model_inst.cyc(s, w, l, c, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(3'b111, 2'b11, 4'hf, 3'b010, 10'h0, 36'h0);
  endtask

  task automatic rst(input logic strap);
    reset = 1'b1;
    burst_order_strap = strap;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    idle(4);
    chk({oe, sleeping, write_accept, tdo, dout}, {4'b0010, 32'h0});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_write;
    for (int i = 0; i < 8; i++) begin
      exp_mem[i] = 36'h9_c35a_a500 + 36'(i) * 36'h1_0101_0101;
      bus(3'b101, 2'b01, 4'hf, 3'b010, 10'(i), exp_mem[i]);
      chk(36'(write_accept), 36'h1);
    end
    exp_mem[8] = 36'h6_0f0f_1234;
    bus(3'b011, 2'b11, 4'hf, 3'b010, 10'h8, 36'h0);
    bus(3'b111, 2'b01, 4'h0, 3'b010, 10'h9, exp_mem[8]);
    idle(3);
    bus(3'b101, 2'b11, 4'hf, 3'b010, 10'h8, 36'h0);
    chk({pout, dout}, exp_mem[8]);
  endtask

  task automatic t_byte;
    for (int g = 0; g < 4; g++) begin
      if (g % 2 == 0) begin
        exp_mem[1][8*g+:8] = 8'hff;
        exp_mem[1][32+g] = 1'b1;
      end
    end
    bus(3'b101, 2'b10, 4'b1010, 3'b010, 10'h1, 36'hf_ffff_ffff);
    bus(3'b101, 2'b11, 4'h0, 3'b010, 10'h2, 36'h0);
    chk({pout, dout}, exp_mem[2]);
    idle(3);
  endtask

  task automatic t_burst(input logic [9:0] a, input logic ilv);
    logic [9:0] n;
    bus(3'b101, 2'b11, 4'hf, 3'b010, a, 36'h0);
    chk({pout, dout}, exp_mem[a]);
    for (int k = 1; k < 4; k++) begin
      n = {a[9:2], ilv ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
      bus(3'b110, 2'b11, 4'hf, 3'b000, 10'h3ff, 36'h0);
      chk({pout, dout}, exp_mem[n]);
      chk(36'(oe), 36'h1);
    end
    bus(3'b111, 2'b11, 4'hf, 3'b000, 10'h3ff, 36'h0);
    chk({pout, dout}, exp_mem[n]);
  endtask

  task automatic t_strobes;
    bus(3'b001, 2'b01, 4'hf, 3'b010, 10'h3, 36'h0);
    bus(3'b011, 2'b11, 4'hf, 3'b110, 10'h5, 36'h0);
    chk({pout, dout}, exp_mem[3]);
    chk(36'(oe), 36'h1);
    bus(3'b011, 2'b11, 4'hf, 3'b010, 10'h6, 36'h0);
    chk({pout, dout}, exp_mem[6]);
    idle(3);
    bus(3'b101, 2'b11, 4'hf, 3'b010, 10'h3, 36'h0);
    chk({pout, dout}, exp_mem[3]);
  endtask

  task automatic t_oe;
    out_drive_n = 1'b1;
    idle(4);
    chk(36'({poe, oe}), 36'h0);
    out_drive_n = 1'b0;
    idle(4);
    chk(36'({poe, oe}), 36'h3);
    bus(3'b101, 2'b11, 4'hf, 3'b000, 10'h0, 36'h0);
    chk(36'(oe), 36'h0);
    bus(3'b101, 2'b11, 4'hf, 3'b010, 10'h0, 36'h0);
    chk(36'(oe), 36'h0);
    idle(1);
    chk(36'(oe), 36'h1);
  endtask

  task automatic t_sleep;
    bus(3'b101, 2'b11, 4'hf, 3'b000, 10'h0, 36'h0);
    idle(1);
    sleep_request = 1'b1;
    idle(6);
    chk(36'({sleeping, oe}), 36'h2);
    sleep_request = 1'b0;
    idle(6);
    chk(36'(sleeping), 36'h0);
    bus(3'b101, 2'b11, 4'hf, 3'b010, 10'h6, 36'h0);
    chk({pout, dout}, exp_mem[6]);
  endtask

  task automatic t_tport;
    tdi = 1'b1;
    tck = 1'b1;
    idle(6);
    chk(36'(tdo), 36'h0);
    tck = 1'b0;
    idle(6);
    chk(36'(tdo), 36'h1);
    tms = 1'b1;
    tck = 1'b1;
    idle(6);
    tck = 1'b0;
    idle(6);
    chk(36'(tdo), 36'h0);
  endtask

  initial begin
    rst(1'b1);
    t_write;
    t_byte;
    t_burst(10'h1, 1'b1);
    t_strobes;
    t_oe;
    t_sleep;
    t_tport;
    rst(1'b0);
    t_write;
    t_burst(10'h6, 1'b0);
    test_done();
  end
endmodule
